/* File: dpll_fb_divider.sv */
/*
 * Dual-modulus feedback divider with fractional accumulator, pulse swallow
 * and phase delay stage, one instance per loop.
 * Assumes the shared dpll_pkg and vco levels synchronous to the 50 MHz clock.
 */

`timescale 1ns/1ns

module dpll_fb_divider (
	input wire logic clk,
	input wire logic srst,
	input wire logic vcoIn,
	input wire logic powerDown,
	input wire logic [5:0] prescBase,
	input wire logic [4:0] aVal,
	input wire logic [11:0] bVal,
	input wire logic [3:0] fractionNumerator,
	input wire logic frac16,
	output logic fbPulse
);
	import dpll_pkg::*;

	dpll_fbdiv_t st_reg;
	dpll_fbdiv_t st_next;
	logic [11:0] bEff;
	logic lastSlice;
	logic [5:0] modCur;
	logic [4:0] sum;
	logic [4:0] fracMod;

	always_comb begin
		st_next = st_reg;
		st_next.fbPulse = 1'b0;
		st_next.vcoPrev = vcoIn;
		bEff = (bVal == 12'h000) ? 12'h001 : bVal;
		// >= so a shorter B or modulus loaded mid-frame cannot overrun
		lastSlice = (st_reg.abCnt >= bEff - 12'h001);
		// modulus control: P+1 while A runs, P for the rest R11 R21
		modCur = (st_reg.abCnt < {7'h00, aVal}) ? prescBase + 6'h01 : prescBase;
		// one extra vco cycle swallowed in the last slice R14
		if (st_reg.swallow && lastSlice) begin
			modCur = modCur + 6'h01;
		end
		fracMod = frac16 ? FRAC_MOD_16 : FRAC_MOD_15; // R13
		sum = {1'b0, st_reg.acc} + {1'b0, fractionNumerator};
		if (vcoIn && !st_reg.vcoPrev) begin
			if (st_reg.prescCnt >= modCur - 6'h01) begin
				st_next.prescCnt = 6'h00;
				if (lastSlice) begin
					st_next.abCnt = 12'h000;
					// accumulate once per comparison cycle R22
					if (sum >= fracMod) begin
						st_next.acc = 4'(sum - fracMod);
						st_next.swallow = 1'b1; // R14
					end else begin
						st_next.acc = sum[3:0];
						st_next.swallow = 1'b0;
					end
					// residual phase sets the delay of the compare edge R15
					st_next.delayCnt = st_next.acc;
					st_next.delayArmed = 1'b1;
				end else begin
					st_next.abCnt = st_reg.abCnt + 12'h001;
				end
			end else begin
				st_next.prescCnt = st_reg.prescCnt + 6'h01;
			end
		end
		if (st_reg.delayArmed) begin
			if (st_reg.delayCnt == 4'h0) begin
				st_next.fbPulse = 1'b1;
				st_next.delayArmed = 1'b0;
			end else begin
				st_next.delayCnt = st_reg.delayCnt - 4'h1;
			end
		end
		if (powerDown) begin
			st_next = '0; // R20
			st_next.vcoPrev = vcoIn;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign fbPulse = st_reg.fbPulse;
endmodule // dpll_fb_divider

/* File: dpll_divider_chain.sv */
/*
 * Divider and phase comparison core of a dual RF/IF synthesizer:
 * reference routing, reference dividers, feedback dividers, detectors
 * the 24-bit load word with its four latches, and the package that the
 * feedback divider shares.
 * Assumes all pin inputs are synchronous to the single 50 MHz clock.
 */
// Notes on behaviour
// R1: one bit selects common or separate reference path
// R2: separate: primary feeds IF, secondary feeds RF
// R3: common: one reference clocks both dividers together
// R4: 15-bit reference dividers, ratio 3 to 32767
// R5: divided reference is the detector reference input
// R6: high variant: 5-bit A, 10-bit B, 4 fraction
// R7: high variant prescalers 16/17 and 32/33
// R8: low variant: 4-bit A, 10-bit B, 4 fraction
// R9: low variant prescalers 8/9 and 16/17
// R10: IF: 8/9 prescaler, 3-bit A, 12-bit B
// R11: prescaler clocks A/B chain, A sets modulus
// R12: locked output is comparison times N plus F
// R13: 4-bit numerator, modulus 15 or 16 select
// R14: accumulator overflow swallows one vco cycle
// R15: phase delay offsets residual fractional phase error
// R16: each detector compares its own reference and feedback
// R17: per-loop polarity bit swaps up and down
// R18: pump acknowledge ends pulses, no dead zone
// R19: MSB-first 24-bit shift, last two bits select
// R20: power down clears counters, restart aligned
// R21: P+1 for A slices, P otherwise, B>=A
// R22: accumulator adds numerator per cycle, wraps

`timescale 1ns/1ns

// ----------------------------------------------------------------
// shared constants, load word layout and types
// ----------------------------------------------------------------
package dpll_pkg;
	// ----------------------------------------------------------------
	// clock and limits
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int REF_IN_MAX_HZ = 50_000_000;
	localparam logic [14:0] REF_RATIO_MIN = 15'h0003;
	// ----------------------------------------------------------------
	// load word layout
	// ----------------------------------------------------------------
	localparam int SHIFT_W = 24;
	localparam logic [1:0] SEL_IF_REF = 2'h0;
	localparam logic [1:0] SEL_IF_FB = 2'h1;
	localparam logic [1:0] SEL_RF_REF = 2'h2;
	localparam logic [1:0] SEL_RF_FB = 2'h3;
	localparam int REF_PATH_BIT = 23;
	localparam int FRAC16_BIT = 22;
	localparam int REF_RATIO_LSB = 2;
	localparam int IF_A_LSB = 2;
	localparam int IF_B_LSB = 5;
	localparam int RF_FRAC_LSB = 2;
	localparam int RF_A_LSB = 6;
	localparam int RF_B_LSB = 11;
	// ----------------------------------------------------------------
	// reset values, prescaler bases and fraction moduli
	// ----------------------------------------------------------------
	localparam logic [14:0] REF_RATIO_RST = 15'h0003;
	localparam logic [11:0] B_RST = 12'h001;
	localparam logic [5:0] PRESC_BASE_8 = 6'h08;
	localparam logic [5:0] PRESC_BASE_16 = 6'h10;
	localparam logic [5:0] PRESC_BASE_32 = 6'h20;
	localparam logic [4:0] FRAC_MOD_15 = 5'h0F;
	localparam logic [4:0] FRAC_MOD_16 = 5'h10;

	// rf prescaler base; the IF loop is fixed at base 8
	typedef enum logic [1:0] {DPLL_PRESC_8, DPLL_PRESC_16, DPLL_PRESC_32} dpll_presc_t;

	// state of one feedback divider
	typedef struct packed {
		logic vcoPrev;
		logic [5:0] prescCnt;
		logic [11:0] abCnt;
		logic [3:0] acc;
		logic swallow;
		logic [3:0] delayCnt;
		logic delayArmed;
		logic fbPulse;
	} dpll_fbdiv_t;
endpackage

module dpll_divider_chain (
	input wire logic clk,
	input wire logic srst,
	input wire logic refInPrimary,
	input wire logic refInSecondary,
	input wire logic rfVcoIn,
	input wire logic ifVcoIn,
	input wire logic serialData,
	input wire logic serialClock,
	input wire logic loadStrobe,
	input wire dpll_pkg::dpll_presc_t rfPrescMode,
	input wire logic rfDetectorPolarity,
	input wire logic ifDetectorPolarity,
	input wire logic rfPowerDown,
	input wire logic ifPowerDown,
	input wire logic rfPumpAck,
	input wire logic ifPumpAck,
	output logic rfPumpUp,
	output logic rfPumpDown,
	output logic ifPumpUp,
	output logic ifPumpDown,
	output logic rfReferenceCompareSignal,
	output logic ifReferenceCompareSignal,
	output logic rfFeedbackCompareSignal,
	output logic ifFeedbackCompareSignal,
	output logic refPathCommonSel,
	output logic [1:0] registerSelectBits
);
	import dpll_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// index 0 is the IF loop, index 1 the RF loop
	typedef struct packed {
		logic [SHIFT_W-1:0] shiftWord;
		logic serialClockPrev;
		logic loadPrev;
		logic [1:0] registerSelectBits;
		logic refPathCommonSel;
		logic frac16;
		logic [1:0][14:0] refRatio;
		logic [2:0] ifA;
		logic [11:0] ifB;
		logic [4:0] rfA;
		logic [9:0] rfB;
		logic [3:0] fractionNumerator;
		logic primPrev;
		logic secPrev;
		logic [1:0][14:0] refCnt;
		logic [1:0] refPulse;
		logic [1:0] upRaw;
		logic [1:0] downRaw;
		logic [1:0] pumpUp;
		logic [1:0] pumpDown;
	} dpll_chain_t;

	dpll_chain_t st_reg;
	dpll_chain_t st_next;

	logic [1:0] fbPulse;
	logic [1:0] refEdge;
	logic [1:0] powerDown;
	logic [1:0] pumpAck;
	logic [1:0] polarity;
	logic [1:0][14:0] ratioEff;
	logic [1:0] upNext;
	logic [1:0] downNext;
	logic [5:0] rfPrescBase;
	logic primEdge;
	logic secEdge;

	// ----------------------------------------------------------------
	// per-loop inputs gathered for the loops below
	// ----------------------------------------------------------------
	assign powerDown = {rfPowerDown, ifPowerDown};
	assign pumpAck = {rfPumpAck, ifPumpAck};
	assign polarity = {rfDetectorPolarity, ifDetectorPolarity};
	// prev flops reset low, so a pin already high at release counts one edge
	assign primEdge = refInPrimary && !st_reg.primPrev;
	assign secEdge = refInSecondary && !st_reg.secPrev;

	// ----------------------------------------------------------------
	// reference routing
	// ----------------------------------------------------------------
	always_comb begin
		// IF always runs from the primary pin R2 R3
		refEdge[0] = primEdge;
		if (st_reg.refPathCommonSel) begin
			// common path: crystal or oscillator on primary drives both R1 R3
			refEdge[1] = primEdge;
		end else begin
			refEdge[1] = secEdge; // R2
		end
	end

	// ----------------------------------------------------------------
	// rf prescaler base
	// ----------------------------------------------------------------
	// the low variant is 8/9 or 16/17, the high variant 16/17 or 32/33
	always_comb begin
		unique case (rfPrescMode)
			DPLL_PRESC_8: rfPrescBase = PRESC_BASE_8; // R9
			DPLL_PRESC_16: rfPrescBase = PRESC_BASE_16; // R7 R9
			DPLL_PRESC_32: rfPrescBase = PRESC_BASE_32; // R7
			default: rfPrescBase = PRESC_BASE_16;
		endcase
	end

	// ----------------------------------------------------------------
	// detector next values, one per loop
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_loop
			// ratios below three are raised to three R4
			assign ratioEff[gi] = (st_reg.refRatio[gi] < REF_RATIO_MIN) ?
				REF_RATIO_MIN : st_reg.refRatio[gi];
			always_comb begin
				// edges latch their request R16
				upNext[gi] = st_reg.upRaw[gi] || st_reg.refPulse[gi];
				downNext[gi] = st_reg.downRaw[gi] || fbPulse[gi];
				// both held until the pump confirms, so short errors still pulse R18
				if (st_reg.upRaw[gi] && st_reg.downRaw[gi] && pumpAck[gi]) begin
					upNext[gi] = st_reg.refPulse[gi];
					downNext[gi] = fbPulse[gi];
				end
				if (powerDown[gi]) begin
					upNext[gi] = 1'b0;
					downNext[gi] = 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.serialClockPrev = serialClock;
		st_next.loadPrev = loadStrobe;
		st_next.primPrev = refInPrimary;
		st_next.secPrev = refInSecondary;
		st_next.refPulse = 2'h0;

		// serial word enters MSB first R19
		if (serialClock && !st_reg.serialClockPrev) begin
			st_next.shiftWord = {st_reg.shiftWord[SHIFT_W-2:0], serialData};
		end

		// rising load edge copies into the latch named by the low bits R19
		if (loadStrobe && !st_reg.loadPrev) begin
			st_next.registerSelectBits = st_reg.shiftWord[1:0];
			unique case (st_reg.shiftWord[1:0])
				SEL_IF_REF: begin
					st_next.refPathCommonSel = st_reg.shiftWord[REF_PATH_BIT]; // R1
					st_next.frac16 = st_reg.shiftWord[FRAC16_BIT]; // R13
					st_next.refRatio[0] = st_reg.shiftWord[REF_RATIO_LSB +: 15];
				end
				SEL_IF_FB: begin
					st_next.ifA = st_reg.shiftWord[IF_A_LSB +: 3]; // R10
					st_next.ifB = st_reg.shiftWord[IF_B_LSB +: 12]; // R10
				end
				SEL_RF_REF: begin
					st_next.refRatio[1] = st_reg.shiftWord[REF_RATIO_LSB +: 15];
				end
				SEL_RF_FB: begin
					st_next.fractionNumerator = st_reg.shiftWord[RF_FRAC_LSB +: 4]; // R13
					st_next.rfA = st_reg.shiftWord[RF_A_LSB +: 5]; // R6 R8
					st_next.rfB = st_reg.shiftWord[RF_B_LSB +: 10]; // R6 R8
				end
			endcase
		end

		// reference dividers: one compare pulse per ratio input edges R4 R5
		for (int i = 0; i < 2; i++) begin
			if (powerDown[i]) begin
				// cleared with the feedback divider so both restart together R20
				st_next.refCnt[i] = 15'h0000;
			end else if (refEdge[i]) begin
				// >= so a ratio lowered mid-count ends the count on the next input edge
				if (st_reg.refCnt[i] >= ratioEff[i] - 15'h0001) begin
					st_next.refCnt[i] = 15'h0000;
					st_next.refPulse[i] = 1'b1; // R5
				end else begin
					st_next.refCnt[i] = st_reg.refCnt[i] + 15'h0001;
				end
			end
			st_next.upRaw[i] = upNext[i];
			st_next.downRaw[i] = downNext[i];
			// polarity low swaps the sense for negative-slope vcos R17
			st_next.pumpUp[i] = polarity[i] ? upNext[i] : downNext[i];
			st_next.pumpDown[i] = polarity[i] ? downNext[i] : upNext[i];
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= '0;
			// ratios and B start at their smallest legal value, not zero
			st_reg.refRatio <= {REF_RATIO_RST, REF_RATIO_RST};
			st_reg.ifB <= B_RST;
			st_reg.rfB <= B_RST[9:0];
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// feedback dividers
	// ----------------------------------------------------------------
	// output frequency is compare rate times P*B+A plus fraction R12 R21
	// B below A gives a shorter divide; software keeps B>=A
	dpll_fb_divider u_if_fb (
		.clk(clk),
		.srst(srst),
		.vcoIn(ifVcoIn),
		.powerDown(ifPowerDown),
		.prescBase(PRESC_BASE_8),
		.aVal({2'h0, st_reg.ifA}),
		.bVal(st_reg.ifB),
		.fractionNumerator(4'h0),
		.frac16(1'b1),
		.fbPulse(fbPulse[0])
	);

	dpll_fb_divider u_rf_fb (
		.clk(clk),
		.srst(srst),
		.vcoIn(rfVcoIn),
		.powerDown(rfPowerDown),
		.prescBase(rfPrescBase),
		.aVal(st_reg.rfA),
		.bVal({2'h0, st_reg.rfB}),
		.fractionNumerator(st_reg.fractionNumerator),
		.frac16(st_reg.frac16),
		.fbPulse(fbPulse[1])
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign ifPumpUp = st_reg.pumpUp[0];
	assign ifPumpDown = st_reg.pumpDown[0];
	assign rfPumpUp = st_reg.pumpUp[1];
	assign rfPumpDown = st_reg.pumpDown[1];
	assign ifReferenceCompareSignal = st_reg.refPulse[0];
	assign rfReferenceCompareSignal = st_reg.refPulse[1];
	assign ifFeedbackCompareSignal = fbPulse[0];
	assign rfFeedbackCompareSignal = fbPulse[1];
	assign refPathCommonSel = st_reg.refPathCommonSel;
	assign registerSelectBits = st_reg.registerSelectBits;
endmodule // dpll_divider_chain

/* File: dpll_chain_properties.sv */
/* assertions on the divider chain top ports.
 * assumes one clock, srst synchronous, sources spaced two cycles */
`timescale 1ns/1ns
module dpll_chain_properties (
	input wire logic clk,
	input wire logic srst,
	input wire logic loadStrobe,
	input wire logic rfPowerDown,
	input wire logic ifPowerDown,
	input wire logic ifPumpAck,
	input wire logic rfDetectorPolarity,
	input wire logic ifDetectorPolarity,
	input wire logic rfPumpUp,
	input wire logic rfPumpDown,
	input wire logic ifPumpUp,
	input wire logic ifPumpDown,
	input wire logic rfReferenceCompareSignal,
	input wire logic ifReferenceCompareSignal,
	input wire logic rfFeedbackCompareSignal,
	input wire logic refPathCommonSel,
	input wire logic [1:0] registerSelectBits
);
	import dpll_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ----
	// steps
	// ----
	sequence sLoad;
		!loadStrobe ##1 loadStrobe;
	endsequence
	sequence sRfRef;
		rfReferenceCompareSignal && !rfPowerDown;
	endsequence
	// ----
	// checks
	// ----
	chk_rf_ref_gap: assert property (rfReferenceCompareSignal |=> !rfReferenceCompareSignal [*5])
		else $error("rf reference pulses too close");
	chk_if_ref_gap: assert property (ifReferenceCompareSignal |=> !ifReferenceCompareSignal [*5])
		else $error("if reference pulses too close");
	chk_sel_load: assert property ($changed(registerSelectBits) |-> $past(loadStrobe) && !$past(loadStrobe, 2))
		else $error("select changed without load");
	chk_path_src: assert property ($changed(refPathCommonSel) |-> registerSelectBits == SEL_IF_REF)
		else $error("path changed by wrong word");
	chk_path_hold: assert property (sLoad ##1 (registerSelectBits != SEL_IF_REF) |-> $stable(refPathCommonSel))
		else $error("path moved on other load");
	chk_rf_up: assert property (sRfRef |-> ##[1:3] (rfDetectorPolarity ? rfPumpUp : rfPumpDown))
		else $error("rf reference pump missing");
	chk_rf_down: assert property (rfFeedbackCompareSignal && !rfPowerDown |-> ##[1:3] (rfDetectorPolarity ? rfPumpDown : rfPumpUp))
		else $error("rf feedback pump missing");
	chk_if_up: assert property (ifReferenceCompareSignal && !ifPowerDown |-> ##[1:3] (ifDetectorPolarity ? ifPumpUp : ifPumpDown))
		else $error("if reference pump missing");
	chk_if_ack: assert property (ifPumpUp && ifPumpDown && ifPumpAck |-> ##[1:4] !(ifPumpUp || ifPumpDown))
		else $error("if pumps not cleared");
	chk_rf_pd: assert property (rfPowerDown [*2] |-> !(rfPumpUp || rfPumpDown || rfFeedbackCompareSignal))
		else $error("rf active in power down");
endmodule // dpll_chain_properties

bind dpll_divider_chain dpll_chain_properties dpll_chain_properties_i (
	.clk(clk),
	.srst(srst),
	.loadStrobe(loadStrobe),
	.rfPowerDown(rfPowerDown),
	.ifPowerDown(ifPowerDown),
	.ifPumpAck(ifPumpAck),
	.rfDetectorPolarity(rfDetectorPolarity),
	.ifDetectorPolarity(ifDetectorPolarity),
	.rfPumpUp(rfPumpUp),
	.rfPumpDown(rfPumpDown),
	.ifPumpUp(ifPumpUp),
	.ifPumpDown(ifPumpDown),
	.rfReferenceCompareSignal(rfReferenceCompareSignal),
	.ifReferenceCompareSignal(ifReferenceCompareSignal),
	.rfFeedbackCompareSignal(rfFeedbackCompareSignal),
	.refPathCommonSel(refPathCommonSel),
	.registerSelectBits(registerSelectBits)
);

/* File: dpll_partner.sv */
/* far side: gated reference and vco sources, charge pump confirm.
 * assumes the bench gates each source off the clock edge */
`timescale 1ns/1ns
module dpll_partner (
	input wire logic clk,
	input wire logic [3:0] srcEn,
	input wire logic rfPumpUp,
	input wire logic rfPumpDown,
	input wire logic ifPumpUp,
	input wire logic ifPumpDown,
	output logic refInPrimary,
	output logic refInSecondary,
	output logic rfVcoIn,
	output logic ifVcoIn,
	output logic rfPumpAck,
	output logic ifPumpAck
);
	// ----
	// sources
	// ----
	initial begin
		{refInPrimary, refInSecondary, rfVcoIn, ifVcoIn, rfPumpAck, ifPumpAck} = 6'h00;
	end
	// a toggle each cycle is 25 MHz; stopped sources park low
	always @(posedge clk) begin
		refInPrimary <= srcEn[0] & ~refInPrimary;
		refInSecondary <= srcEn[1] & ~refInSecondary;
		rfVcoIn <= srcEn[2] & ~rfVcoIn;
		ifVcoIn <= srcEn[3] & ~ifVcoIn;
		// confirm only once both directions are on
		rfPumpAck <= rfPumpUp & rfPumpDown;
		ifPumpAck <= ifPumpUp & ifPumpDown;
	end
endmodule // dpll_partner

/* File: tb_dpll_divider_chain.sv */
/* bench of the divider chain: serial loads, gated sources, pulse counts.
 * assumes dpll_partner toggles each enabled source once a clock */
`timescale 1ns/1ns
module tb_dpll_divider_chain;
	import dpll_pkg::*;
	logic clk, srst, serialData, serialClock, loadStrobe, rfPowerDown, ifPowerDown;
	logic rfDetectorPolarity, ifDetectorPolarity, refInPrimary, refInSecondary;
	logic rfVcoIn, ifVcoIn, rfPumpAck, ifPumpAck, rfPumpUp, rfPumpDown, ifPumpUp, ifPumpDown;
	logic rfReferenceCompareSignal, ifReferenceCompareSignal, refPathCommonSel;
	logic rfFeedbackCompareSignal, ifFeedbackCompareSignal;
	logic [1:0] registerSelectBits;
	logic [3:0] srcEn;
	dpll_presc_t rfPrescMode;
	int nErrors, samplesChecked, cycles, nRfRef, nIfRef, nRfFb, nIfFb;

	dpll_divider_chain dpll_divider_chain_i (
		.clk(clk),
		.srst(srst),
		.refInPrimary(refInPrimary),
		.refInSecondary(refInSecondary),
		.rfVcoIn(rfVcoIn),
		.ifVcoIn(ifVcoIn),
		.serialData(serialData),
		.serialClock(serialClock),
		.loadStrobe(loadStrobe),
		.rfPrescMode(rfPrescMode),
		.rfDetectorPolarity(rfDetectorPolarity),
		.ifDetectorPolarity(ifDetectorPolarity),
		.rfPowerDown(rfPowerDown),
		.ifPowerDown(ifPowerDown),
		.rfPumpAck(rfPumpAck),
		.ifPumpAck(ifPumpAck),
		.rfPumpUp(rfPumpUp),
		.rfPumpDown(rfPumpDown),
		.ifPumpUp(ifPumpUp),
		.ifPumpDown(ifPumpDown),
		.rfReferenceCompareSignal(rfReferenceCompareSignal),
		.ifReferenceCompareSignal(ifReferenceCompareSignal),
		.rfFeedbackCompareSignal(rfFeedbackCompareSignal),
		.ifFeedbackCompareSignal(ifFeedbackCompareSignal),
		.refPathCommonSel(refPathCommonSel),
		.registerSelectBits(registerSelectBits)
	);
	dpll_partner dpll_partner_i (
		.clk(clk),
		.srcEn(srcEn),
		.rfPumpUp(rfPumpUp),
		.rfPumpDown(rfPumpDown),
		.ifPumpUp(ifPumpUp),
		.ifPumpDown(ifPumpDown),
		.refInPrimary(refInPrimary),
		.refInSecondary(refInSecondary),
		.rfVcoIn(rfVcoIn),
		.ifVcoIn(ifVcoIn),
		.rfPumpAck(rfPumpAck),
		.ifPumpAck(ifPumpAck)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		nRfRef += int'(rfReferenceCompareSignal === 1'b1);
		nIfRef += int'(ifReferenceCompareSignal === 1'b1);
		nRfFb += int'(rfFeedbackCompareSignal === 1'b1);
		nIfFb += int'(ifFeedbackCompareSignal === 1'b1);
		if (cycles == 40000) begin
			nErrors++;
			report_and_stop();
		end
	end
	// ----
	// helpers
	// ----
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samplesChecked++;
		if (seen !== exp) begin
			nErrors++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, what, seen, exp);
		end
	endtask
	task automatic load(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			serialData = w[i];
			cyc(1);
			serialClock = 1'b1;
			cyc(1);
			serialClock = 1'b0;
		end
		loadStrobe = 1'b1;
		cyc(1);
		loadStrobe = 1'b0;
		cyc(2);
		check(registerSelectBits, w[1:0], "select");
	endtask
	// n rising edges, then a tail long enough for the delay stage
	task automatic burst(input logic [3:0] en, input int n);
		srcEn = en;
		cyc(2 * n);
		srcEn = 4'h0;
		cyc(40);
	endtask
	task automatic settle();
		rfPowerDown = 1'b1;
		ifPowerDown = 1'b1;
		cyc(3);
		check(rfPumpUp | rfPumpDown | ifPumpUp | ifPumpDown, 1'b0, "pump in power down");
		{nRfRef, nIfRef, nRfFb, nIfFb} = '0;
		rfPowerDown = 1'b0;
		ifPowerDown = 1'b0;
		cyc(1);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset();
		check(registerSelectBits, SEL_IF_REF, "select at reset");
		check(refPathCommonSel, 1'b0, "path at reset");
	endtask
	task automatic t_ref();
		load({2'h0, 5'h00, 15'h0005, 2'h0});
		load({7'h00, 15'h0003, 2'h2});
		settle();
		burst(4'h1, 15);
		check(nIfRef, 3, "if from primary");
		check(nRfRef, 0, "rf from primary");
		settle();
		burst(4'h2, 15);
		check(nIfRef, 0, "if from secondary");
		check(nRfRef, 5, "rf from secondary");
		check(rfPumpUp, 1'b1, "rf pump up");
		load({2'h2, 5'h00, 15'h0005, 2'h0});
		check(refPathCommonSel, 1'b1, "common path");
		settle();
		burst(4'h1, 15);
		check(nIfRef, 3, "if common");
		check(nRfRef, 5, "rf common");
	endtask
	task automatic t_fb();
		dpll_presc_t md[6] = '{DPLL_PRESC_8, DPLL_PRESC_16, DPLL_PRESC_32, DPLL_PRESC_32,
			DPLL_PRESC_8, DPLL_PRESC_8};
		int pb[6] = '{8, 16, 32, 32, 8, 8};
		int av[6] = '{0, 2, 0, 31, 0, 7};
		int bv[6] = '{9, 17, 33, 33, 7, 7};
		int n;
		logic [3:0] en;
		logic [1:0] pumps;
		for (int k = 0; k < 6; k++) begin
			rfPrescMode = md[k];
			rfDetectorPolarity = (k != 2);
			n = pb[k] * bv[k] + av[k];
			en = (k > 3) ? 4'h8 : 4'h4;
			if (k > 3) begin
				load({7'h00, bv[k][11:0], av[k][2:0], 2'h1});
			end else begin
				load({3'h0, bv[k][9:0], av[k][4:0], 4'h0, 2'h3});
			end
			settle();
			burst(en, 2 * n - 1);
			check(nRfFb + nIfFb, 1, "frame short");
			burst(en, 1);
			check(nRfFb + nIfFb, 2, "frame whole");
			pumps = (k > 3) ? {ifPumpUp, ifPumpDown} : {rfPumpUp, rfPumpDown};
			check(pumps, (k == 2) ? 2'h2 : 2'h1, "fb pump");
		end
	endtask
	task automatic t_frac();
		logic f16[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
		logic [3:0] num[4] = '{4'h8, 4'h8, 4'hA, 4'hA};
		int extra[4] = '{0, 1, 1, 1};
		int want[4] = '{3, 4, 3, 4};
		rfPrescMode = DPLL_PRESC_16;
		for (int k = 0; k < 4; k++) begin
			load({1'b0, f16[k], 5'h00, 15'h0003, 2'h0});
			load({3'h0, 10'h011, 5'h02, num[k], 2'h3});
			settle();
			burst(4'h4, 4 * (16 * 17 + 2) + extra[k]);
			check(nRfFb, want[k], "fraction");
		end
	endtask
	task automatic t_det();
		load({2'h0, 5'h00, 15'h0003, 2'h0});
		load({7'h00, 12'h007, 3'h0, 2'h1});
		for (int p = 0; p < 2; p++) begin
			ifDetectorPolarity = p[0];
			settle();
			burst(4'h1, 3);
			check(ifPumpUp, p[0], "if up");
			check(ifPumpDown, !p[0], "if down");
			burst(4'h8, 56);
			check(ifPumpUp | ifPumpDown, 1'b0, "pumps cleared");
		end
		ifDetectorPolarity = 1'b1;
	endtask
	task automatic report_and_stop();
		$display("errors %0d checks %0d", nErrors, samplesChecked);
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		{srst, serialData, serialClock, loadStrobe, rfPowerDown, ifPowerDown} = 6'h20;
		{rfDetectorPolarity, ifDetectorPolarity, srcEn} = 6'h30;
		rfPrescMode = DPLL_PRESC_16;
		{nErrors, samplesChecked, cycles, nRfRef, nIfRef, nRfFb, nIfFb} = '0;
		cyc(2);
		srst = 1'b0;
		cyc(1);
		t_reset();
		t_ref();
		t_fb();
		t_frac();
		t_det();
		report_and_stop();
	end
endmodule // tb_dpll_divider_chain
